// >>> test/pin_partner.sv
module pin_partner (
	input wire logic aclk, // system clock
	input wire logic slow, // long event pulses
	input wire logic [15:0] ev_req, // event target count
	input wire logic [1:0] cap_lvl, // wanted capture levels
	input wire logic [3:0] pulse_output_pin, // pwm load side
	output logic ext_clock_pin = 1'b0, // event clock
	output logic [15:0] ev_done = '0, // events sent
	output logic [1:0] capture_input_pin = 2'b01 // capture lines
);
	timeunit 1ns;
	timeprecision 1ns;
	int ph = 0;
	// event clock idles low between bursts
	always @(posedge aclk) begin
		capture_input_pin <= cap_lvl;
		if (ph != 0)
			ph <= ph - 1;
		else if (ext_clock_pin || ev_done != ev_req) begin
			ext_clock_pin <= !ext_clock_pin;
			ev_done <= ev_done + 16'(!ext_clock_pin);
			ph <= slow ? 2 : 0;
		end
	end
endmodule

// >>> test/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import art_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, halt_mode = 1'b0, slow = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, v;
	logic [3:0] wstrb = 4'hf, pulse_output_pin, pulse_output_enable;
	logic awready, wready, bvalid, arready, rvalid, ext_clock_pin;
	logic wrap_irq, capture_irq, wake_request;
	logic [1:0] bresp, rresp, r, capture_input_pin, cap_lvl = 2'b01;
	logic [15:0] ev_req = '0, ev_done;
	logic [7:0] p, dd;
	logic [7:0] cf[5] = '{8'h08, 8'h38, 8'h78, 8'h00, 8'h88};
	logic [7:0] du[4] = '{8'hd0, 8'he0, 8'hf0, 8'hc8};
	int ex[5] = '{128, 16, 1, 0, 64};
	int eh[4] = '{64, 128, 64, 0};
	int n_mismatch = 0, comparisons = 0, n_wake = 0, hi[4];

	pwm_auto_reload_timer pwm_auto_reload_timer_i (.aclk, .aresetn,
		.awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .halt_mode, .ext_clock_pin,
		.capture_input_pin, .pulse_output_pin, .pulse_output_enable,
		.wrap_irq, .capture_irq, .wake_request);
	pin_partner pin_partner_i (.aclk, .slow, .ev_req, .cap_lvl,
		.pulse_output_pin, .ext_clock_pin, .ev_done, .capture_input_pin);

	initial forever #5 aclk = ~aclk;
	always @(posedge aclk) if (wake_request === 1'b1) n_wake <= n_wake + 1;

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		awaddr <= ADDR_W'({i, 2'b00});
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask

	task automatic rd(input logic [7:0] i);
		araddr <= ADDR_W'({i, 2'b00});
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
	endtask

	task automatic cnt();
		hi = '{default: 0};
		repeat (256) begin
			@(posedge aclk);
			for (int c = 0; c < 4; c++) hi[c] += int'(pulse_output_pin[c]);
		end
	endtask

	task automatic caps();
		cap_lvl <= 2'b10;
		wt(4);
		cap_lvl <= 2'b01;
		wt(4);
	endtask

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		wt(20000);
		n_mismatch++;
		finish_test();
	end

	initial begin
		wt(12);
		aresetn <= 1'b1;
		wt(2);
		for (int i = 8'h73; i <= 8'h7d; i++) begin
			rd(8'(i));
			chk(32'h0, v);
		end
		rd(8'h7e);
		chk(RESP_SLVERR, r);
		wr(8'h72, 8'h55);
		chk(RESP_SLVERR, r);
		wr(IDX_COUNTER, 8'h5a);
		rd(IDX_COUNTER);
		chk(8'h5a, v);
		// counter advance over a 128 cycle window per setting
		for (int k = 0; k < 5; k++) begin
			if (cf[k][7]) ev_req <= ev_done + 16'd200;
			wr(IDX_TIMER_CSR, cf[k]);
			rd(IDX_COUNTER);
			p = v[7:0];
			wt(126);
			rd(IDX_COUNTER);
			dd = v[7:0] - p;
			chk(ex[k], dd);
		end
		wr(IDX_TIMER_CSR, 8'h00);
		while (ev_done != ev_req) wt(1);
		slow <= 1'b1;
		wr(IDX_RELOAD, 8'hfd);
		wr(IDX_TIMER_CSR, 8'h86);
		rd(IDX_TIMER_CSR);
		chk(1'b0, v[2]);
		rd(IDX_COUNTER);
		chk(8'hfd, v);
		wr(IDX_TIMER_CSR, 8'h8a);
		ev_req <= ev_req + 16'd2;
		wt(20);
		rd(IDX_TIMER_CSR);
		chk(8'h8a, v);
		ev_req <= ev_req + 16'd1;
		wt(12);
		chk(1'b1, wrap_irq);
		rd(IDX_TIMER_CSR);
		chk(8'h8b, v);
		rd(IDX_TIMER_CSR);
		chk(8'h8a, v);
		rd(IDX_COUNTER);
		chk(8'hfd, v);
		wr(IDX_RELOAD, 8'hc0);
		for (int c = 0; c < 4; c++) wr(IDX_DUTY0 - 8'(c), du[c]);
		wr(IDX_PULSE_CTRL, 8'h74);
		wr(IDX_TIMER_CSR, 8'h0c);
		wt(80);
		cnt();
		for (int c = 0; c < 4; c++) chk(eh[c], hi[c]);
		chk(4'b0111, pulse_output_enable);
		wr(IDX_DUTY0, 8'he0);
		wr(IDX_PULSE_CTRL, 8'h70);
		wt(64);
		cnt();
		chk(192, hi[2]);
		chk(128, hi[0]);
		wr(IDX_TIMER_CSR, 8'h00);
		wr(IDX_COUNTER, 8'h5a);
		wr(IDX_CAPTURE_CSR, 8'h1c);
		cap_lvl <= 2'b10;
		wt(4);
		rd(IDX_CAPTURE_CSR);
		chk(8'h1c, v);
		cap_lvl <= 2'b01;
		wt(4);
		rd(IDX_CAPTURE_CSR);
		chk(8'h1f, v);
		chk(1'b1, capture_irq);
		wr(IDX_COUNTER, 8'h33);
		caps();
		rd(IDX_CAPTURED1);
		chk(8'h5a, v);
		rd(IDX_CAPTURE_CSR);
		chk(8'h1e, v);
		wt(2);
		chk(1'b1, capture_irq);
		rd(IDX_CAPTURED2);
		chk(8'h5a, v);
		wt(2);
		chk(1'b0, capture_irq);
		caps();
		rd(IDX_CAPTURED1);
		chk(8'h33, v);
		chk(0, n_wake);
		halt_mode <= 1'b1;
		caps();
		chk(1'b1, n_wake > 0);
		finish_test();
	end
endmodule

// >>> verilog/art_pkg.sv
// Function
// - counter increments once per prescaler output tick, eight bits wide
// - on overflow counter reloads from auto-reload value; prescaler untouched
// - software reads and writes the live counter through counter access
// - counter access write or forced reload also clears 7-bit prescaler
// - prescaler divides input by two to the power of divider select
// - source select 0 takes cpu clock, 1 takes external clock pin
// - count enable clear freezes prescaler and counter; set lets them run
// - reset clears counter and prescaler and selects cpu clock
// - force reload bit reads zero; writing one loads reload value
// - four hidden compares copy duty values only at overflow
// - output enable bit makes its channel pin a driven output
// - all channels share a period of 256 minus reload value
// - overflow sets pin opposite to polarity bit; compare match sets it to polarity bit
// - overflow sets wrap flag, request if enabled; status read clears it
// - with external clock and divider select 0, flag sets after 256 minus reload events
// - pulse generation stops while the chip is halted
// - active capture edge latches counter and sets capture flag
// - further captures blocked until capture register read; read clears flag
// - capture request pending while flag and its enable are set
// - enabled capture edge wakes the chip from halt
// - edge select 0 triggers on falling edge, 1 on rising edge
// - polarity change inverts channel output at once
package art_pkg;
	localparam int unsigned NUM_PWM = 4;
	localparam int unsigned NUM_CAP = 2;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_DUTY3 = 8'h73;
	localparam logic [7:0] IDX_DUTY2 = 8'h74;
	localparam logic [7:0] IDX_DUTY1 = 8'h75;
	localparam logic [7:0] IDX_DUTY0 = 8'h76;
	localparam logic [7:0] IDX_PULSE_CTRL = 8'h77;
	localparam logic [7:0] IDX_TIMER_CSR = 8'h78;
	localparam logic [7:0] IDX_COUNTER = 8'h79;
	localparam logic [7:0] IDX_RELOAD = 8'h7a;
	localparam logic [7:0] IDX_CAPTURE_CSR = 8'h7b;
	localparam logic [7:0] IDX_CAPTURED1 = 8'h7c;
	localparam logic [7:0] IDX_CAPTURED2 = 8'h7d;
	localparam int unsigned ADDR_W = 12;
	// timer_control_status fields
	localparam int unsigned CSR_EXT_BIT = 7;
	localparam int unsigned CSR_DIV_LSB = 4;
	localparam int unsigned CSR_EN_BIT = 3;
	localparam int unsigned CSR_FORCE_BIT = 2;
	localparam int unsigned CSR_WIE_BIT = 1;
	// capture_control_status fields
	localparam int unsigned CAP_EDGE_LSB = 4;
	localparam int unsigned CAP_IE_LSB = 2;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [6:0] PRESC_RESET = 7'h00;
	localparam logic [7:0] COUNT_TOP = 8'hff;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic ext_sel;
		logic [2:0] div_sel;
		logic cnt_en;
		logic wrap_ie;
	} timer_cfg_type;

	typedef struct packed {
		logic [NUM_CAP-1:0] edge_sel;
		logic [NUM_CAP-1:0] ie;
	} capture_cfg_type;

	localparam timer_cfg_type TIMER_CFG_RESET = '0;
	localparam capture_cfg_type CAPTURE_CFG_RESET = '0;
endpackage

// >>> verilog/pwm_auto_reload_timer.sv
module pwm_auto_reload_timer (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [art_pkg::ADDR_W-1:0] awaddr, // write address
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write strobes
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	output logic [1:0] bresp, // write response
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [art_pkg::ADDR_W-1:0] araddr, // read address
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	input wire logic halt_mode, // chip in halt state
	input wire logic ext_clock_pin, // external event clock
	input wire logic [1:0] capture_input_pin, // capture inputs
	output logic [3:0] pulse_output_pin, // pwm pin levels
	output logic [3:0] pulse_output_enable, // pin driven as output
	output logic wrap_irq, // overflow request
	output logic capture_irq, // capture request
	output logic wake_request // halt wakeup pulse
);
	import art_pkg::*;

	timer_cfg_type cfg_q;
	capture_cfg_type cap_cfg_q;
	logic [7:0] reload_q;
	logic [7:0] cnt_q, cnt_d;
	logic [6:0] presc_q, presc_d;
	logic [7:0] duty_q [NUM_PWM];
	logic [7:0] cmp_q [NUM_PWM];
	logic [3:0] oe_q, pol_q, phase_q, phase_d;
	logic wrap_flag_q;
	logic [1:0] cap_flag_q;
	logic [7:0] captured_q [NUM_CAP];
	logic ext_prev_q;
	logic [1:0] cap_prev_q;
	logic aw_full_q, w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0] w_byte_q;
	logic w_strb_q;

	// bus decode
	logic wr_fire, wr_en, rd_fire;
	logic [7:0] wr_idx, rd_idx, rd_byte;
	logic rd_hit, wr_hit;
	assign wr_fire = aw_full_q & w_full_q & ~bvalid;
	assign wr_en = wr_fire & w_strb_q;
	assign wr_idx = aw_addr_q[9:2];
	assign rd_fire = arvalid & arready;
	assign rd_idx = araddr[9:2];
	assign wr_hit = (wr_idx >= IDX_DUTY3) && (wr_idx <= IDX_CAPTURED2);
	assign rd_hit = (rd_idx >= IDX_DUTY3) && (rd_idx <= IDX_CAPTURED2);

	logic cnt_wr, force_wr;
	assign cnt_wr = wr_en && wr_idx == IDX_COUNTER;
	assign force_wr = wr_en && wr_idx == IDX_TIMER_CSR &&
		w_byte_q[CSR_FORCE_BIT];

	// counter clocking
	logic ext_rise, tick_in, cnt_tick, wrap;
	logic [6:0] tap_mask;
	assign ext_rise = ext_clock_pin & ~ext_prev_q;
	assign tick_in = cfg_q.cnt_en & ~halt_mode &
		(cfg_q.ext_sel ? ext_rise : 1'b1);
	assign tap_mask = 7'((8'h01 << cfg_q.div_sel) - 8'h01);
	assign cnt_tick = tick_in & ((presc_q & tap_mask) == tap_mask);
	assign wrap = cnt_tick & (cnt_q == COUNT_TOP);

	always_comb begin
		cnt_d = cnt_q;
		presc_d = presc_q;
		if (cnt_wr) begin
			cnt_d = w_byte_q;
			presc_d = PRESC_RESET;
		end else if (force_wr) begin
			cnt_d = reload_q;
			presc_d = PRESC_RESET;
		end else if (tick_in) begin
			presc_d = presc_q + 7'h01;
			if (wrap)
				cnt_d = reload_q;
			else if (cnt_tick)
				cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= REG_RESET;
			presc_q <= PRESC_RESET;
			ext_prev_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			presc_q <= presc_d;
			ext_prev_q <= ext_clock_pin;
		end
	end

	// software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= TIMER_CFG_RESET;
			cap_cfg_q <= CAPTURE_CFG_RESET;
			reload_q <= REG_RESET;
			oe_q <= 4'h0;
			pol_q <= 4'h0;
			for (int i = 0; i < NUM_PWM; i++)
				duty_q[i] <= REG_RESET;
		end else if (wr_en) begin
			unique case (wr_idx)
				IDX_DUTY0: duty_q[0] <= w_byte_q;
				IDX_DUTY1: duty_q[1] <= w_byte_q;
				IDX_DUTY2: duty_q[2] <= w_byte_q;
				IDX_DUTY3: duty_q[3] <= w_byte_q;
				IDX_PULSE_CTRL: begin
					oe_q <= w_byte_q[7:4];
					pol_q <= w_byte_q[3:0];
				end
				IDX_TIMER_CSR: begin
					cfg_q.ext_sel <= w_byte_q[CSR_EXT_BIT];
					cfg_q.div_sel <= w_byte_q[CSR_DIV_LSB +: 3];
					cfg_q.cnt_en <= w_byte_q[CSR_EN_BIT];
					cfg_q.wrap_ie <= w_byte_q[CSR_WIE_BIT];
				end
				IDX_RELOAD: reload_q <= w_byte_q;
				IDX_CAPTURE_CSR: begin
					cap_cfg_q.edge_sel <= w_byte_q[CAP_EDGE_LSB +: 2];
					cap_cfg_q.ie <= w_byte_q[CAP_IE_LSB +: 2];
				end
				default: ;
			endcase
		end
	end

	// pwm generation
	always_comb begin
		phase_d = phase_q;
		for (int i = 0; i < NUM_PWM; i++) begin
			if (wrap)
				phase_d[i] = 1'b1;
			else if (cnt_tick && cnt_d == cmp_q[i])
				phase_d[i] = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= 4'h0;
			for (int i = 0; i < NUM_PWM; i++)
				cmp_q[i] <= REG_RESET;
		end else begin
			phase_q <= phase_d;
			if (wrap) begin
				for (int i = 0; i < NUM_PWM; i++)
					cmp_q[i] <= duty_q[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_output_pin <= 4'h0;
			pulse_output_enable <= 4'h0;
		end else begin
			pulse_output_enable <= oe_q;
			if (!halt_mode)
				pulse_output_pin <= oe_q & (phase_d ^ pol_q);
		end
	end

	// overflow flag, set wins over the read clear
	logic csr_read;
	assign csr_read = rd_fire && rd_idx == IDX_TIMER_CSR;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wrap_flag_q <= 1'b0;
			wrap_irq <= 1'b0;
		end else begin
			if (wrap)
				wrap_flag_q <= 1'b1;
			else if (csr_read)
				wrap_flag_q <= 1'b0;
			wrap_irq <= (wrap_flag_q | wrap) & cfg_q.wrap_ie;
		end
	end

	// capture channels
	logic [1:0] cap_edge, cap_read, cap_take;
	always_comb begin
		for (int c = 0; c < NUM_CAP; c++) begin
			cap_edge[c] = cap_cfg_q.edge_sel[c] ?
				(capture_input_pin[c] & ~cap_prev_q[c]) :
				(~capture_input_pin[c] & cap_prev_q[c]);
			cap_read[c] = rd_fire && rd_idx == IDX_CAPTURED1 + 8'(c);
			cap_take[c] = cap_edge[c] &
				(~cap_flag_q[c] | cap_read[c]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_prev_q <= 2'b00;
			cap_flag_q <= 2'b00;
			capture_irq <= 1'b0;
			wake_request <= 1'b0;
			for (int c = 0; c < NUM_CAP; c++)
				captured_q[c] <= REG_RESET;
		end else begin
			cap_prev_q <= capture_input_pin;
			for (int c = 0; c < NUM_CAP; c++) begin
				if (cap_take[c]) begin
					captured_q[c] <= cnt_q;
					cap_flag_q[c] <= 1'b1;
				end else if (cap_read[c]) begin
					cap_flag_q[c] <= 1'b0;
				end
			end
			capture_irq <= |((cap_flag_q | cap_take) & cap_cfg_q.ie);
			wake_request <= halt_mode & |(cap_edge & cap_cfg_q.ie);
		end
	end

	// axi4-lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			aw_addr_q <= '0;
			w_byte_q <= REG_RESET;
			w_strb_q <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full_q <= 1'b1;
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_full_q <= 1'b1;
				wready <= 1'b0;
				w_byte_q <= wdata[7:0];
				w_strb_q <= wstrb[0];
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// axi4-lite read channel
	always_comb begin
		unique case (rd_idx)
			IDX_DUTY0: rd_byte = duty_q[0];
			IDX_DUTY1: rd_byte = duty_q[1];
			IDX_DUTY2: rd_byte = duty_q[2];
			IDX_DUTY3: rd_byte = duty_q[3];
			IDX_PULSE_CTRL: rd_byte = {oe_q, pol_q};
			IDX_TIMER_CSR: rd_byte = {cfg_q.ext_sel, cfg_q.div_sel,
				cfg_q.cnt_en, 1'b0, cfg_q.wrap_ie, wrap_flag_q};
			IDX_COUNTER: rd_byte = cnt_q;
			IDX_RELOAD: rd_byte = reload_q;
			IDX_CAPTURE_CSR: rd_byte = {2'b00, cap_cfg_q.edge_sel,
				cap_cfg_q.ie, cap_flag_q};
			IDX_CAPTURED1: rd_byte = captured_q[0];
			IDX_CAPTURED2: rd_byte = captured_q[1];
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			if (rd_fire) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h00_0000, rd_byte};
				rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence plain_tick_s;
		cnt_tick && !wrap && !cnt_wr && !force_wr;
	endsequence

	sequence capture_event_s;
		cap_edge[0] && !cap_flag_q[0];
	endsequence

	cnt_step_a: assert property (
		plain_tick_s |=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("counter did not step on tick");
	reload_wrap_a: assert property (
		wrap && !cnt_wr && !force_wr |=> cnt_q == $past(reload_q)
		&& presc_q == $past(presc_q) + 7'h01)
		else $error("overflow reload wrong");
	access_write_a: assert property (
		cnt_wr |=> cnt_q == $past(w_byte_q) && presc_q == PRESC_RESET)
		else $error("counter access write wrong");
	force_load_a: assert property (
		force_wr && !cnt_wr |=> cnt_q == $past(reload_q)
		&& presc_q == PRESC_RESET)
		else $error("forced reload wrong");
	div_one_a: assert property (
		cfg_q.div_sel == 3'h0 |-> cnt_tick == tick_in)
		else $error("divide by one misses ticks");
	freeze_a: assert property (
		!cfg_q.cnt_en && !cnt_wr && !force_wr
		|=> $stable(cnt_q) && $stable(presc_q))
		else $error("counter moved while disabled");
	compare_load_a: assert property (
		wrap |=> cmp_q[0] == $past(duty_q[0])
		&& cmp_q[3] == $past(duty_q[3]))
		else $error("hidden compare not loaded");
	wrap_flag_a: assert property (
		wrap ##1 cfg_q.wrap_ie |-> wrap_flag_q ##1 wrap_irq)
		else $error("overflow flag or request missing");
	capture_latch_a: assert property (
		capture_event_s |=> cap_flag_q[0] && captured_q[0] == $past(cnt_q))
		else $error("capture not latched");
	capture_block_a: assert property (
		cap_flag_q[1] && !cap_read[1] |=> $stable(captured_q[1])
		&& cap_flag_q[1])
		else $error("capture overwritten before read");
	halt_hold_a: assert property (
		halt_mode |=> $stable(pulse_output_pin))
		else $error("pwm ran during halt");
	compare_hold_a: assert property (
		!wrap |=> $stable(cmp_q[1]) && $stable(cmp_q[2]))
		else $error("hidden compare changed between overflows");
	flag_clear_a: assert property (
		csr_read && !wrap |=> !wrap_flag_q)
		else $error("overflow flag not cleared by status read");
	capture_clear_a: assert property (
		cap_read[0] && !cap_take[0] |=> !cap_flag_q[0])
		else $error("capture flag not cleared by read");
	pin_disable_a: assert property (
		!oe_q[3] && !halt_mode |=> !pulse_output_pin[3])
		else $error("disabled channel pin driven high");
	wake_pulse_a: assert property (
		!halt_mode |=> !wake_request)
		else $error("wake request outside halt");
	edge_select_a: assert property (
		cap_edge[1] |-> capture_input_pin[1] == cap_cfg_q.edge_sel[1])
		else $error("capture edge of wrong direction");
endmodule
